// ==== bench/ssi_host_model.sv ====
`timescale 1ns/1ps
// host side: keeps the last image it was handed at each update tick
module ssi_host_model (
  input  wire logic                clk_in,
  input  wire logic                tick_in,
  input  wire ssi_pkg::ssi_image_s image_in,
  output ssi_pkg::ssi_image_s      snap_out,
  output int                       n_snaps_out
);
  initial begin
    snap_out = '0;
    n_snaps_out = 0;
  end
  // capture only on the tick, so a half-built image is never seen
  always @(posedge clk_in) begin
    if (tick_in === 1'b1) begin
      snap_out <= image_in;
      n_snaps_out <= n_snaps_out + 1;
    end
  end
endmodule : ssi_host_model

// ==== bench/ssi_status_image_test.sv ====
`timescale 1ns/1ps
`include "ssi_defs.svh"
module ssi_status_image_test;
  logic                clk, rst_n, hsel, hwrite, hrdy, hresp, tick, soff;
  logic [1:0]          htrans;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [15:0]         pins;
  ssi_pkg::ssi_core_s  core, cv;
  ssi_pkg::ssi_image_s img, snap;
  int                  n_errors, total_checks, seed, m_app, m_ser, k, snapn, c;
  ssi_status_image #(.UPDATE_CYCLES(8), .EXTENDED(1'b1)) u_ssi_status_image (
    .core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .core_in(core), .case_pins_in(pins), .image_out(img), .image_tick_out(tick),
    .safety_off_out(soff));
  ssi_host_model u_ssi_host_model (.clk_in(clk), .tick_in(tick), .image_in(img),
    .snap_out(snap), .n_snaps_out(snapn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // bounded wait for hready at a rising edge
  task hwait;
    int i;
    i = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i == 20) begin
      n_errors++;
      wrap_up();
    end
  endtask : hwait
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : bus
  // wait for n images to reach the host, never forever
  task snaps(input int n);
    int i, s;
    repeat (n) begin
      s = snapn;
      i = 0;
      while (snapn == s && i < 40) begin
        @(posedge clk);
        i++;
      end
      if (i == 40) begin
        n_errors++;
        wrap_up();
      end
    end
  endtask : snaps
  // expected image: live fields plus the two sticky model flags
  function automatic ssi_pkg::ssi_image_s exp_img();
    ssi_pkg::ssi_image_s e;
    e = {m_app[0], core[45:44], m_ser[0], core[42:40], pins, core[39:0]};
    // a case byte of 255 is no case number and reads as none
    for (int b = 0; b < 4; b++) begin
      if (e[b*8+:8] == 8'hFF) e[b*8+:8] = 8'h00;
    end
    return e;
  endfunction : exp_img
  task check_all;
    ssi_pkg::ssi_image_s e;
    e = exp_img();
    chk(snap, e);
    chk(soff, core.dirty_err | core.tamper | core.contour_miss);
    bus(1'b0, `SSI_OFS_FLAGS, 32'h0);
    chk(rd, {core.contour_miss, core.tamper, m_ser[0], core.dirty_warn, core.dirty_err, m_app[0]});
    bus(1'b0, `SSI_OFS_INPUTS, 32'h0);
    chk(rd, {core.inputs_ok, pins});
    bus(1'b0, `SSI_OFS_CASES, 32'h0);
    chk(rd, e[31:0]);
    bus(1'b0, `SSI_OFS_PATHS, 32'h0);
    chk(rd, core.path_free);
  endtask : check_all
  initial begin
    seed = 45;
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, pins, core} = '0;
    {m_app, m_ser, n_errors, total_checks} = '0;
    repeat (11) @(posedge clk);
    #1;
    chk({soff, img}, {1'b1, 63'h0});
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `SSI_OFS_CTRL, 32'h0);
    chk(rd, `SSI_CTRL_RESET);
    bus(1'b0, 32'h0000_0100, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    // random live conditions; sticky causes stay low so the model flags hold
    for (k = 0; k < 8; k++) begin
      cv = 47'({$random(seed), $random(seed)});
      cv.app_err = 1'b0;
      cv.serious_err = 1'b0;
      for (c = 0; c < 4; c++) cv[c*8+:8] = 8'($unsigned($random(seed)) % 255);
      if (k == 0) cv[15:0] = 16'hFE00;
      if (k == 1) cv.case_tbl_two = 8'hFF;
      core <= cv;
      pins <= 16'($random(seed));
      snaps(3);
      check_all();
    end
    $display("random image test done");
    // app fault is sticky until cause gone and safety restart
    core.app_err <= 1'b1;
    m_app = 1;
    snaps(2);
    bus(1'b1, `SSI_OFS_CTRL, 32'h0000_0003);
    snaps(2);
    check_all();
    core.app_err <= 1'b0;
    snaps(2);
    check_all();
    bus(1'b1, `SSI_OFS_CTRL, 32'h0000_0003);
    m_app = 0;
    snaps(2);
    check_all();
    $display("app fault test done");
    // serious fault ignores a safety restart, needs device restart
    core.serious_err <= 1'b1;
    m_ser = 1;
    snaps(2);
    core.serious_err <= 1'b0;
    bus(1'b1, `SSI_OFS_CTRL, 32'h0000_0003);
    snaps(2);
    check_all();
    bus(1'b1, `SSI_OFS_CTRL, 32'h0000_0005);
    m_ser = 0;
    snaps(2);
    check_all();
    $display("serious fault test done");
    // updates off: image must not move while inputs change
    bus(1'b1, `SSI_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    c = snapn;
    core.path_free <= ~core.path_free;
    repeat (30) @(posedge clk);
    chk(snapn, c);
    bus(1'b1, `SSI_OFS_CTRL, 32'h0000_0001);
    snaps(2);
    check_all();
    $display("update enable test done");
    // reset in mid-run acts as device restart for the serious flag
    core.serious_err <= 1'b1;
    m_ser = 1;
    snaps(2);
    check_all();
    rst_n <= 1'b0;
    core.serious_err <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    m_ser = 0;
    @(posedge clk);
    snaps(2);
    check_all();
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : ssi_status_image_test

// ==== hdl/ssi_defs.svh ====
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH
// register byte offsets
`define SSI_OFS_CTRL    8'h00
`define SSI_OFS_FLAGS   8'h04
`define SSI_OFS_INPUTS  8'h08
`define SSI_OFS_CASES   8'h0C
`define SSI_OFS_PATHS   8'h10
`define SSI_OFS_SEQ     8'h14
// control register fields
`define SSI_CTRL_UPD_EN   0
`define SSI_CTRL_RST_SAFE 1
`define SSI_CTRL_RST_DEV  2
`define SSI_CTRL_RESET    32'h0000_0001
// status field positions and values
`define SSI_INPUTS_OK_BIT 16
`define SSI_CASE_NONE     8'h00
`define SSI_CASE_MAX      8'hFE
`define SSI_LOW_PATHS     4
// update timing
`define SSI_UPDATE_NS     5000000
`define SSI_CLK_NS        50
`endif

// ==== hdl/ssi_pkg.sv ====
package ssi_pkg;
  // live conditions from the scanner core, same clock
  typedef struct packed {
    logic       app_err;
    logic       dirty_err;
    logic       dirty_warn;
    logic       serious_err;
    logic       tamper;
    logic       contour_miss;
    logic       inputs_ok;
    logic [7:0] path_free;
    logic [7:0] case_tbl_four;
    logic [7:0] case_tbl_three;
    logic [7:0] case_tbl_two;
    logic [7:0] case_tbl_one;
  } ssi_core_s;
  // consistent image handed to the network
  typedef struct packed {
    logic       app_fault_flag;
    logic       dirty_window_fault;
    logic       dirty_window_warning;
    logic       serious_fault_flag;
    logic       tamper_flag;
    logic       contour_mismatch_flag;
    logic       case_inputs_ok;
    logic [15:0] case_inputs;
    logic [7:0] plain_path_state;
    logic [7:0] active_case_tbl_four;
    logic [7:0] active_case_tbl_three;
    logic [7:0] active_case_tbl_two;
    logic [7:0] active_case_tbl_one;
  } ssi_image_s;
endpackage : ssi_pkg

// ==== hdl/ssi_status_image.sv ====
`timescale 1ns/1ps
`include "ssi_defs.svh"
module ssi_status_image #(
  parameter int UPDATE_CYCLES = `SSI_UPDATE_NS / `SSI_CLK_NS,
  parameter bit EXTENDED      = 1'b1
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic [31:0]            hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire ssi_pkg::ssi_core_s core_in,
  input  wire logic [15:0]       case_pins_in,
  output ssi_pkg::ssi_image_s    image_out,
  output logic                   image_tick_out,
  output logic                   safety_off_out
);

  generate
    if (UPDATE_CYCLES < 2) begin : g_bad_period
      $error("UPDATE_CYCLES must be at least 2");
    end
  endgenerate

  // a byte of 255 is not a legal case number, so it shows as no case
  function automatic logic [7:0] case_clamp(input logic [7:0] v);
    case_clamp = (v > `SSI_CASE_MAX) ? `SSI_CASE_NONE : v;
  endfunction : case_clamp

  // write target test, shared by the ctrl register and both restart pulses
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == `SSI_OFS_CTRL);
  endfunction : is_ctrl

  // case-select pins come from outside, two flops before use
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;
  always_ff @(posedge core_clk_in) begin
    pin_meta_reg <= case_pins_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // ahb-lite address phase capture
  logic        ap_valid;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] seq_reg;
  logic [31:0] rd_mux;
  logic        rst_safe_pulse;
  logic        rst_dev_pulse;
  assign ap_valid      = hsel_in & htrans_in[1] & hready_in;
  assign hreadyout_out = 1'b1; // zero wait states, always ready
  assign hresp_out     = 1'b0; // always okay
  assign rst_safe_pulse = wr_pend_reg & is_ctrl(wr_addr_reg) & hwdata_in[`SSI_CTRL_RST_SAFE];
  assign rst_dev_pulse  = wr_pend_reg & is_ctrl(wr_addr_reg) & hwdata_in[`SSI_CTRL_RST_DEV];

  // sticky fault flags: the raising cause always beats the clearing command
  logic app_flag_reg;
  logic app_flag_next;
  logic serious_reg;
  logic serious_next;
  assign app_flag_next = core_in.app_err
                       | (app_flag_reg & ~(rst_safe_pulse | rst_dev_pulse));
  assign serious_next  = core_in.serious_err | (serious_reg & ~rst_dev_pulse);
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      app_flag_reg <= 1'b0;
      serious_reg  <= 1'b0;
    end else begin
      app_flag_reg <= app_flag_next;
      serious_reg  <= serious_next;
    end
  end

  // safety outputs follow the live causes, not the slower image
  logic safety_off_next;
  assign safety_off_next = core_in.dirty_err | core_in.tamper | core_in.contour_miss;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      safety_off_out <= 1'b1; // outputs start off until proven free
    end else begin
      safety_off_out <= safety_off_next;
    end
  end

  // network update divider
  logic [31:0] tick_cnt_reg;
  logic        tick;
  assign tick = ctrl_reg[`SSI_CTRL_UPD_EN] & (tick_cnt_reg == 32'(UPDATE_CYCLES - 1));
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (ctrl_reg[`SSI_CTRL_UPD_EN]) begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // assemble the next image from live state
  logic [7:0]          path_mask;
  ssi_pkg::ssi_image_s image_next;
  assign path_mask = EXTENDED ? 8'hFF : {{`SSI_LOW_PATHS{1'b0}}, {`SSI_LOW_PATHS{1'b1}}};
  assign image_next = '{
    app_fault_flag:        app_flag_reg,
    dirty_window_fault:    core_in.dirty_err,
    dirty_window_warning:  core_in.dirty_warn,
    serious_fault_flag:    serious_reg,
    tamper_flag:           core_in.tamper,
    contour_mismatch_flag: core_in.contour_miss,
    case_inputs_ok:        core_in.inputs_ok,
    case_inputs:           pin_sync_reg,
    plain_path_state:      core_in.path_free & path_mask,
    active_case_tbl_four:  case_clamp(core_in.case_tbl_four),
    active_case_tbl_three: case_clamp(core_in.case_tbl_three),
    active_case_tbl_two:   case_clamp(core_in.case_tbl_two),
    active_case_tbl_one:   case_clamp(core_in.case_tbl_one)
  };

  // whole image moves in one edge so the host never sees a torn mix
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      image_out      <= '0;
      image_tick_out <= 1'b0;
      seq_reg        <= 32'h0000_0000;
    end else begin
      image_tick_out <= tick;
      if (tick) begin
        image_out <= image_next;
        seq_reg   <= seq_reg + 32'h0000_0001;
      end
    end
  end

  // register read decode; status words come from the snapshot, ctrl and seq from their own registers
  logic [7:0] ap_addr;
  assign ap_addr = haddr_in[7:0];

  // read words, each built once from the held image
  logic [31:0] flags_word;
  logic [31:0] inputs_word;
  logic [31:0] cases_word;
  logic [31:0] paths_word;
  assign flags_word  = {26'h000_0000, image_out.contour_mismatch_flag,
                        image_out.tamper_flag, image_out.serious_fault_flag,
                        image_out.dirty_window_warning, image_out.dirty_window_fault,
                        image_out.app_fault_flag};
  assign inputs_word = {15'h0000, image_out.case_inputs_ok, image_out.case_inputs};
  assign cases_word  = {image_out.active_case_tbl_four, image_out.active_case_tbl_three,
                        image_out.active_case_tbl_two, image_out.active_case_tbl_one};
  assign paths_word  = {24'h00_0000, image_out.plain_path_state};
  assign rd_mux =
    (haddr_in[31:8] != 24'h00_0000) ? 32'h0000_0000 :
    (ap_addr == `SSI_OFS_CTRL)   ? ctrl_reg :
    (ap_addr == `SSI_OFS_FLAGS)  ? flags_word :
    (ap_addr == `SSI_OFS_INPUTS) ? inputs_word :
    (ap_addr == `SSI_OFS_CASES)  ? cases_word :
    (ap_addr == `SSI_OFS_PATHS)  ? paths_word :
    (ap_addr == `SSI_OFS_SEQ)    ? seq_reg :
                                   32'h0000_0000;

  // bus state: read data is loaded at the address phase edge
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_out  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ap_valid & hwrite_in & (haddr_in[31:8] == 24'h00_0000);
      wr_addr_reg <= haddr_in[7:0];
      if (ap_valid && !hwrite_in) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  // only the enable bit is stored; restart bits act as pulses
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= `SSI_CTRL_RESET;
    end else if (wr_pend_reg && is_ctrl(wr_addr_reg)) begin
      ctrl_reg <= {31'h0000_0000, hwdata_in[`SSI_CTRL_UPD_EN]};
    end
  end

  // checks
  app_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    app_flag_reg && !rst_safe_pulse && !rst_dev_pulse |=> app_flag_reg)
    else $error("app fault flag dropped without restart");
  app_set_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.app_err |=> app_flag_reg)
    else $error("app fault flag missed its cause");
  dirty_off_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.dirty_err |=> safety_off_out)
    else $error("dirty fault left outputs on");
  warn_only_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.dirty_warn && !core_in.dirty_err && !core_in.tamper && !core_in.contour_miss |=> !safety_off_out)
    else $error("warning forced outputs off");
  pins_mirror_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.case_inputs == $past(pin_meta_reg, 2))
    else $error("input mirror not from pins");
  valid_bit_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.case_inputs_ok == $past(core_in.inputs_ok))
    else $error("validity bit wrong");
  case_range_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    image_out.active_case_tbl_one != 8'hFF && image_out.active_case_tbl_two != 8'hFF &&
    image_out.active_case_tbl_three != 8'hFF && image_out.active_case_tbl_four != 8'hFF)
    else $error("case number out of range");
  serious_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    serious_reg && !rst_dev_pulse |=> serious_reg)
    else $error("serious fault cleared without device restart");
  tamper_off_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.tamper |=> safety_off_out)
    else $error("tamper left outputs on");
  path_free_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.plain_path_state[0] == $past(core_in.path_free[0]))
    else $error("path state wrong");
  contour_off_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.contour_miss |=> safety_off_out && $past(safety_off_next))
    else $error("contour mismatch left outputs on");
  upper_paths_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !EXTENDED |-> image_out.plain_path_state[7:4] == 4'h0)
    else $error("upper paths shown in base variant");
  image_still_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !tick |=> $stable(image_out))
    else $error("image changed between network cycles");

  // sticky flags must set on their cause and let go once cause and restart allow it
  app_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    app_flag_reg && rst_safe_pulse && !core_in.app_err |=> !app_flag_reg)
    else $error("app fault flag kept after restart");
  serious_set_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_in.serious_err |=> serious_reg)
    else $error("serious fault flag missed its cause");
  serious_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    serious_reg && rst_dev_pulse && !core_in.serious_err |=> !serious_reg)
    else $error("serious fault kept after device restart");

  // outputs come back on once every forcing cause is gone
  safe_on_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !core_in.dirty_err && !core_in.tamper && !core_in.contour_miss |=> !safety_off_out)
    else $error("outputs held off without a cause");

  // each live flag lands in the image on the update edge
  dirty_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.dirty_window_fault == $past(core_in.dirty_err))
    else $error("dirty fault flag wrong");
  warn_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.dirty_window_warning == $past(core_in.dirty_warn))
    else $error("dirty warning flag wrong");
  tamper_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.tamper_flag == $past(core_in.tamper))
    else $error("tamper flag wrong");
  contour_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.contour_mismatch_flag == $past(core_in.contour_miss))
    else $error("contour flag wrong");
  case_none_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick && core_in.case_tbl_two > `SSI_CASE_MAX |=> image_out.active_case_tbl_two == `SSI_CASE_NONE)
    else $error("illegal case byte not shown as none");
  path_low_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_out.plain_path_state[3:0] == $past(core_in.path_free[3:0]))
    else $error("lower path states wrong");
  path_high_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    EXTENDED && tick |=> image_out.plain_path_state[7:4] == $past(core_in.path_free[7:4]))
    else $error("upper path states wrong");

  // update timing and the snapshot counter
  tick_out_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> image_tick_out)
    else $error("update pulse missing");
  tick_pulse_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    image_tick_out |=> !image_tick_out)
    else $error("update pulse longer than one cycle");
  seq_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick |=> seq_reg == $past(seq_reg) + 32'h0000_0001)
    else $error("image counter did not step");
  cnt_bound_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tick_cnt_reg < 32'(UPDATE_CYCLES))
    else $error("update divider ran past its period");

  // bus side: enable bit written, read data held between reads
  ctrl_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    wr_pend_reg && is_ctrl(wr_addr_reg) |=> ctrl_reg[`SSI_CTRL_UPD_EN] == $past(hwdata_in[`SSI_CTRL_UPD_EN]))
    else $error("update enable not written");
  rd_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !(ap_valid && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved without a read");

endmodule : ssi_status_image
